// [rtl/ptbi_pkg.sv]
package ptbi_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, 32-bit aligned words)
    // ----------------------------------------------------------------
    localparam logic [7:0] PTBI_CTRL_ADDR = 8'h00;
    localparam logic [7:0] PTBI_IRQ_STATUS_ADDR = 8'h04;
    localparam logic [7:0] PTBI_IRQ_CLEAR_ADDR = 8'h08;
    localparam logic [7:0] PTBI_IRQ_ENABLE_ADDR = 8'h0c;
    localparam logic [7:0] PTBI_MODE_ADDR = 8'h10;

    // ----------------------------------------------------------------
    // timebase_control field positions
    // ----------------------------------------------------------------
    localparam int PTBI_FLAG_BIT = 7;
    localparam int PTBI_RATE_LO = 4;
    localparam int PTBI_ACK_BIT = 3;
    localparam int PTBI_IE_BIT = 2;
    localparam int PTBI_ON_BIT = 1;
    localparam logic [2:0] PTBI_RATE_RESET = 3'h0;

    // mode register: bit0 wait, bit1 stop, bit2 osc_in_stop_enable
    localparam int PTBI_WAIT_BIT = 0;
    localparam int PTBI_STOP_BIT = 1;
    localparam int PTBI_OSCSTOP_BIT = 2;

    // status/clear/enable layout: bit0 rollover event
    localparam int PTBI_EVT_BIT = 0;

    // divider chain bit whose rising edge marks each rate's event
    localparam int PTBI_TAP_0 = 14;
    localparam int PTBI_TAP_1 = 12;
    localparam int PTBI_TAP_2 = 10;
    localparam int PTBI_TAP_3 = 6;
    localparam int PTBI_TAP_4 = 5;
    localparam int PTBI_TAP_5 = 4;
    localparam int PTBI_TAP_6 = 3;
    localparam int PTBI_TAP_7 = 2;

    localparam int PTBI_STAGES = 15;
    localparam int PTBI_SYNC_STAGES = 2;

    typedef struct packed {
        logic [2:0] rate_select;
        logic irq_enable;
        logic module_enable;
    } ptbi_ctrl_t;

    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic osc_in_stop_enable;
    } ptbi_mode_t;

endpackage

// [rtl/ptbi_timebase.sv]
`timescale 1ns/100ps
module ptbi_timebase
    import ptbi_pkg::*;
#(
    parameter int STAGES = PTBI_STAGES
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // crystal clock pin, sampled
    input wire logic crystal_clock,
    // interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // crystal clock synchroniser and edge detect
    // ----------------------------------------------------------------
    logic xtal_meta;
    logic xtal_sync;
    logic xtal_prev;
    logic xtal_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            xtal_meta <= crystal_clock;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
        end
    end

    // one tick per crystal period; pclk must be well above 65.5 kHz
    assign xtal_rise = xtal_sync & ~xtal_prev;

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    ptbi_ctrl_t ctrl;
    ptbi_mode_t mode;
    logic pending_flag;
    logic evt_status;
    logic evt_enable;
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;
    logic chain_run;
    logic tap_now;
    logic tap_next;
    logic overflow;

    logic wr_en;
    logic rd_en;
    logic reg_locked;
    logic addr_ok;
    logic ack_write;
    logic clr_write;

    // the cpu cannot reach the control register in wait or stop
    assign reg_locked = mode.wait_mode | mode.stop_mode;

    function automatic logic known_addr(input logic [7:0] a);
        return (a == PTBI_CTRL_ADDR) || (a == PTBI_IRQ_STATUS_ADDR) ||
            (a == PTBI_IRQ_CLEAR_ADDR) || (a == PTBI_IRQ_ENABLE_ADDR) ||
            (a == PTBI_MODE_ADDR);
    endfunction

    assign addr_ok = known_addr(paddr);
    assign wr_en = psel & penable & pwrite & addr_ok;
    // read data is captured in the setup cycle so it stands with pready
    assign rd_en = psel & ~penable & ~pwrite;

    // ctrl access blocked while locked; write is dropped
    assign ack_write = wr_en && (paddr == PTBI_CTRL_ADDR) && !reg_locked &&
        pwdata[PTBI_ACK_BIT];
    assign clr_write = wr_en && (paddr == PTBI_IRQ_CLEAR_ADDR) && pwdata[PTBI_EVT_BIT];

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl.rate_select <= PTBI_RATE_RESET;
            ctrl.irq_enable <= 1'b0;
            ctrl.module_enable <= 1'b0;
        end else if (wr_en && paddr == PTBI_CTRL_ADDR && !reg_locked) begin
            // rate is stored even when enabled; software must not do that
            ctrl.rate_select <= pwdata[PTBI_RATE_LO +: 3];
            ctrl.irq_enable <= pwdata[PTBI_IE_BIT];
            ctrl.module_enable <= pwdata[PTBI_ON_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= '0;
        end else if (wr_en && paddr == PTBI_MODE_ADDR) begin
            mode.wait_mode <= pwdata[PTBI_WAIT_BIT];
            mode.stop_mode <= pwdata[PTBI_STOP_BIT];
            mode.osc_in_stop_enable <= pwdata[PTBI_OSCSTOP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // divider chain
    // ----------------------------------------------------------------
    // stop freezes the chain unless the oscillator keeps running
    assign chain_run = ~mode.stop_mode | mode.osc_in_stop_enable;

    function automatic logic tap_bit(input logic [STAGES-1:0] c, input logic [2:0] r);
        unique case (r)
            3'h0: return c[PTBI_TAP_0];
            3'h1: return c[PTBI_TAP_1];
            3'h2: return c[PTBI_TAP_2];
            3'h3: return c[PTBI_TAP_3];
            3'h4: return c[PTBI_TAP_4];
            3'h5: return c[PTBI_TAP_5];
            3'h6: return c[PTBI_TAP_6];
            3'h7: return c[PTBI_TAP_7];
        endcase
    endfunction

    always_comb begin
        next_chain = chain;
        if (xtal_rise && chain_run) begin
            next_chain = chain + {{(STAGES-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain <= '0;
        end else if (!ctrl.module_enable) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    // the tap is the msb of the selected divide, so its rising edge
    // comes half a period after start, then every full period
    assign tap_now = tap_bit(chain, ctrl.rate_select);
    assign tap_next = tap_bit(next_chain, ctrl.rate_select);
    assign overflow = ctrl.module_enable & ~tap_now & tap_next;

    // ----------------------------------------------------------------
    // pending flag and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_flag <= 1'b0;
        end else if (overflow) begin
            pending_flag <= 1'b1;
        end else if (ack_write) begin
            pending_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= 1'b0;
        end else if (overflow) begin
            evt_status <= 1'b1;
        end else if (clr_write || ack_write) begin
            evt_status <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_enable <= 1'b0;
        end else if (wr_en && paddr == PTBI_IRQ_ENABLE_ADDR) begin
            evt_enable <= pwdata[PTBI_EVT_BIT];
        end
    end

    // registered: one cycle behind the flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (pending_flag & ctrl.irq_enable) | (evt_status & evt_enable);
        end
    end

    // ----------------------------------------------------------------
    // apb answer: zero wait states
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known_addr(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= '0;
            unique case (paddr)
                PTBI_CTRL_ADDR: begin
                    if (!reg_locked) begin
                        prdata[PTBI_FLAG_BIT] <= pending_flag;
                        prdata[PTBI_RATE_LO +: 3] <= ctrl.rate_select;
                        prdata[PTBI_ACK_BIT] <= 1'b0;
                        prdata[PTBI_IE_BIT] <= ctrl.irq_enable;
                        prdata[PTBI_ON_BIT] <= ctrl.module_enable;
                    end
                end
                PTBI_IRQ_STATUS_ADDR: prdata[PTBI_EVT_BIT] <= evt_status;
                PTBI_IRQ_ENABLE_ADDR: prdata[PTBI_EVT_BIT] <= evt_enable;
                PTBI_MODE_ADDR: begin
                    prdata[PTBI_WAIT_BIT] <= mode.wait_mode;
                    prdata[PTBI_STOP_BIT] <= mode.stop_mode;
                    prdata[PTBI_OSCSTOP_BIT] <= mode.osc_in_stop_enable;
                end
                default: prdata <= '0;
            endcase
        end
    end

endmodule

// [tb/ptbi_monitor.sv]
`timescale 1ns/100ps
// ----------------------------------------
// bus answer and read-back checks
// ----------------------------------------
module ptbi_monitor
    import ptbi_pkg::*;
#(
    parameter int STAGES = PTBI_STAGES
) (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic crystal_clock,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_done_s;
        pready && !pwrite;
    endsequence
    ready_follow_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_phase_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h10
        |=> !pslverr)
        else $error("mapped access refused");
    ack_zero_a: assert property (rd_done_s ##0 paddr == PTBI_CTRL_ADDR |-> !prdata[PTBI_ACK_BIT])
        else $error("acknowledge bit read as one");
    upper_zero_a: assert property (rd_done_s |-> prdata[31:8] == 24'h0)
        else $error("unused read bits set");
endmodule

bind ptbi_timebase ptbi_monitor #(.STAGES(STAGES)) mon_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
    .irq(irq));

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench
    import ptbi_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic irq, pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, ex, seed = 32'h33;
    logic [1:0] xc = 2'h0;
    int err_count = 0, n_compared = 0, cyc = 0, t0, n;
    int dv[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
    int md[3] = '{1, 2, 6};
    // ----------------------------------------
    // clocks and design
    // ----------------------------------------
    always #50 pclk = ~pclk;
    // crystal runs at a quarter of pclk so long divides finish in time
    always @(posedge pclk) begin
        xc <= xc + 2'h1;
        cyc <= cyc + 1;
    end
    ptbi_timebase dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_clock(xc[1]), .irq(irq));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one idle edge at the end keeps back-to-back calls from double driving
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic wirq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge pclk);
        err_count++;
        report_and_stop();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(PTBI_CTRL_ADDR, 32'h0);
        rd(PTBI_IRQ_ENABLE_ADDR, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({q[31:1], e}, 32'h1);
        for (int r = 1; r < 8; r++) begin
            q = rnd();
            ex = {24'h0, 1'b0, r[2:0], 4'h6};
            t0 = cyc;
            apb(1'b1, PTBI_CTRL_ADDR, {q[31:8], q[7], r[2:0], 3'h3, q[0]});
            rd(PTBI_CTRL_ADDR, ex);
            wirq(dv[r] * 4);
            chk(cyc - t0 >= dv[r] * 2 - 4 && cyc - t0 <= dv[r] * 2 + 12, 1);
            t0 = cyc;
            apb(1'b1, PTBI_CTRL_ADDR, ex);
            rd(PTBI_CTRL_ADDR, ex | 32'h80);
            apb(1'b1, PTBI_CTRL_ADDR, ex | 32'h8);
            rd(PTBI_CTRL_ADDR, ex);
            chk({31'h0, irq}, 32'h0);
            wirq(dv[r] * 8);
            chk(cyc - t0, dv[r] * 4);
            apb(1'b1, PTBI_CTRL_ADDR, 32'h8);
        end
        apb(1'b1, PTBI_CTRL_ADDR, 32'h42);
        wirq(300);
        chk(n, 300);
        rd(PTBI_IRQ_STATUS_ADDR, 32'h1);
        rd(PTBI_CTRL_ADDR, 32'hc2);
        apb(1'b1, PTBI_IRQ_ENABLE_ADDR, 32'h1);
        rd(PTBI_IRQ_ENABLE_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, PTBI_IRQ_CLEAR_ADDR, 32'h1);
        rd(PTBI_IRQ_STATUS_ADDR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, PTBI_CTRL_ADDR, 32'h8);
        apb(1'b1, PTBI_IRQ_ENABLE_ADDR, 32'h0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, PTBI_CTRL_ADDR, 32'h76);
            apb(1'b1, PTBI_MODE_ADDR, md[i]);
            rd(PTBI_CTRL_ADDR, 32'h0);
            wirq(80);
            chk(n < 80, md[i] != 2);
            apb(1'b1, PTBI_MODE_ADDR, 32'h0);
            apb(1'b1, PTBI_CTRL_ADDR, 32'h8);
        end
        report_and_stop();
    end
endmodule
